//--- spi_port_defines.svh
// What this block does
// - every register is one 8-bit byte
// - bit order: 0 low-first, 1 high-first
// - streaming: 0 one byte, 1 many
// - address step: 0 down, 1 up
// - wiring: 0 three-wire, 1 four-wire
// - select high: ignore pins, back ready
// - early abort leaves no side effects
// - keep finished bytes, drop partial byte
// - four-wire: read data on output line
// - three-wire: shared line, output off
// - launch on falling, sample on rising
// - float both pins unless driving reads
// - slave only, 16-bit control word first
// - bit 15 read flag, rest address
// - undefined address: drop writes, read zero
// - low-first: address low up, flag last
// - high-first: flag, address high down
// - step up wraps last to zero
// - step down wraps zero to last
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// serial word sizes
`define CMD_BITS 16
`define ADDR_BITS 15
`define DATA_BITS 8
`define RW_BIT 15
// bit counter width and terminal counts
`define CNT_W 4
`define CMD_LAST 4'hF
`define DATA_LAST 4'h7
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
// implemented register space
`define NUM_REGS 16
`define LAST_REG 15'h000F
`define ADDR_ZERO 15'h0000
`define ADDR_ONE 15'h0001
`define BYTE_ZERO 8'h00
// settings reset: high-first, single byte, step up, four-wire
`define CFG_W 4
`define CFG_RST 4'hB
`define HOST_SYNC_W 2

`endif

//--- spi_port_pkg.sv
`default_nettype none
`include "spi_port_defines.svh"

package spi_port_pkg;

    // frame phases, one-hot
    typedef enum logic [3:0] {
        ST_CMD = 4'h1,
        ST_WDATA = 4'h2,
        ST_RDATA = 4'h4,
        ST_DONE = 4'h8
    } frame_state_e;

    // port settings, packed msb first in this order
    typedef struct packed {
        logic high_bit_first;
        logic multi_byte_enable;
        logic address_step_up;
        logic separate_lines_mode;
    } port_cfg_s;

    // rising-edge frame state, cleared by chip select
    typedef struct packed {
        frame_state_e state;
        logic [`CNT_W-1:0] cnt;
        logic [`CMD_BITS-1:0] cmd;
        logic [`ADDR_BITS-1:0] addr;
        logic [`DATA_BITS-1:0] wsh;
    } frame_s;

    // falling-edge launch state, cleared by chip select
    typedef struct packed {
        logic out_bit;
        logic [`DATA_BITS-1:0] tx;
        logic oe_sep;
        logic oe_pin;
    } launch_s;

    // register storage and write event, cleared by system reset
    typedef struct packed {
        logic [`NUM_REGS-1:0][`DATA_BITS-1:0] regs;
        logic wr_tgl;
        logic [`ADDR_BITS-1:0] wr_addr;
        logic [`DATA_BITS-1:0] wr_data;
    } store_s;

    // system clock side state
    typedef struct packed {
        logic tgl_seen;
        logic wr_pulse;
        logic [`ADDR_BITS-1:0] wr_addr;
        logic [`DATA_BITS-1:0] wr_data;
        logic active;
    } host_s;

endpackage : spi_port_pkg

`default_nettype wire

//--- level_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two flip-flop synchroniser for quasi-static levels
module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta_ff;

    // both stages load the reset constant
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_ff <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_ff <= d_in;
            q_out <= meta_ff;
        end
    end

endmodule : level_sync

`default_nettype wire

//--- spi_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_defines.svh"

// serial control port slave with a small byte register space
module spi_port
    import spi_port_pkg::*;
(
    // system side
    input wire logic clk_in,
    input wire logic arst_n_in,
    // port settings, expected to be static during frames
    input wire logic high_bit_first_in,
    input wire logic multi_byte_enable_in,
    input wire logic address_step_up_in,
    input wire logic separate_lines_mode_in,
    // serial link pins
    input wire logic sclk_in,
    input wire logic chip_select_n_in,
    input wire logic data_inout_pin_in,
    output logic data_inout_pin_out,
    output logic data_inout_pin_oe_out,
    output logic serial_data_out_out,
    output logic serial_data_out_oe_out,
    // committed write report and frame activity on the system clock
    output logic reg_wr_pulse_out,
    output logic [`ADDR_BITS-1:0] reg_wr_addr_out,
    output logic [`DATA_BITS-1:0] reg_wr_data_out,
    output logic frame_active_out
);

    // helpers

    // byte at an address; unmapped space reads zero
    function automatic logic [`DATA_BITS-1:0] read_byte(
        input store_s st,
        input logic [`ADDR_BITS-1:0] a
    );
        logic [`DATA_BITS-1:0] b;
        b = `BYTE_ZERO;
        if (a <= `LAST_REG) begin
            b = st.regs[a[$clog2(`NUM_REGS)-1:0]];
        end
        return b;
    endfunction : read_byte

    // next streaming address with wrap at both ends
    function automatic logic [`ADDR_BITS-1:0] step_addr(
        input logic [`ADDR_BITS-1:0] a,
        input logic up
    );
        logic [`ADDR_BITS-1:0] n;
        n = a;
        if (up) begin
            // wrap from the last register to zero
            n = (a == `LAST_REG) ? `ADDR_ZERO : a + `ADDR_ONE;
        end else begin
            // wrap from zero to the last register
            n = (a == `ADDR_ZERO) ? `LAST_REG : a - `ADDR_ONE;
        end
        return n;
    endfunction : step_addr

    // settings brought onto the link clock

    // raw setting pins as one word
    port_cfg_s cfg_raw;
    // settings as seen by the link logic
    port_cfg_s cfg;
    logic [`CFG_W-1:0] cfg_q;

    // gather the setting inputs
    always_comb begin
        cfg_raw.high_bit_first = high_bit_first_in;
        cfg_raw.multi_byte_enable = multi_byte_enable_in;
        cfg_raw.address_step_up = address_step_up_in;
        cfg_raw.separate_lines_mode = separate_lines_mode_in;
    end

    // settings cross on link clock edges; defaults hold until then
    level_sync #(
        .WIDTH(`CFG_W),
        .RST_VAL(`CFG_RST)
    ) u_cfg_sync (
        .clk_in(sclk_in),
        .arst_n_in(arst_n_in),
        .d_in(cfg_raw),
        .q_out(cfg_q)
    );

    // synchronised settings as a struct
    assign cfg = port_cfg_s'(cfg_q);

    // rising-edge frame logic

    // frame state and its next value
    frame_s frame_ff;
    frame_s nxt_frame;
    // register storage and its next value
    store_s store_ff;
    store_s nxt_store;
    // shifted words including the bit on the line now
    logic [`CMD_BITS-1:0] cmd_shift;
    logic [`DATA_BITS-1:0] data_shift;
    // a write byte finishes on this edge
    logic wr_done;

    // shift in one bit in the chosen order
    always_comb begin
        // both orders leave the flag at the top
        if (cfg.high_bit_first) begin
            cmd_shift = {frame_ff.cmd[`CMD_BITS-2:0], data_inout_pin_in};
            data_shift = {frame_ff.wsh[`DATA_BITS-2:0], data_inout_pin_in};
        end else begin
            cmd_shift = {data_inout_pin_in, frame_ff.cmd[`CMD_BITS-1:1]};
            data_shift = {data_inout_pin_in, frame_ff.wsh[`DATA_BITS-1:1]};
        end
    end

    // next frame state
    always_comb begin
        nxt_frame = frame_ff;
        wr_done = 1'b0;
        nxt_frame.cnt = frame_ff.cnt + `CNT_ONE;
        unique case (frame_ff.state)
            // collect the 16-bit control word
            ST_CMD: begin
                nxt_frame.cmd = cmd_shift;
                if (frame_ff.cnt == `CMD_LAST) begin
                    nxt_frame.cnt = `CNT_ZERO;
                    // top bit picks read, the rest is the address
                    nxt_frame.addr = cmd_shift[`ADDR_BITS-1:0];
                    if (cmd_shift[`RW_BIT]) begin
                        nxt_frame.state = ST_RDATA;
                    end else begin
                        nxt_frame.state = ST_WDATA;
                    end
                end
            end
            // collect one write byte
            ST_WDATA: begin
                nxt_frame.wsh = data_shift;
                if (frame_ff.cnt == `DATA_LAST) begin
                    // commit only on the eighth bit
                    wr_done = 1'b1;
                    nxt_frame.cnt = `CNT_ZERO;
                    if (cfg.multi_byte_enable) begin
                        nxt_frame.addr = step_addr(frame_ff.addr,
                            cfg.address_step_up);
                    end else begin
                        // single byte per frame
                        nxt_frame.state = ST_DONE;
                    end
                end
            end
            // count out one read byte
            ST_RDATA: begin
                if (frame_ff.cnt == `DATA_LAST) begin
                    nxt_frame.cnt = `CNT_ZERO;
                    if (cfg.multi_byte_enable) begin
                        nxt_frame.addr = step_addr(frame_ff.addr,
                            cfg.address_step_up);
                    end else begin
                        nxt_frame.state = ST_DONE;
                    end
                end
            end
            // ignore further clocks until select rises
            ST_DONE: begin
                nxt_frame.cnt = frame_ff.cnt;
            end
            default: begin
                nxt_frame.state = ST_DONE;
            end
        endcase
    end

    // select high holds the frame at ready
    always_ff @(posedge sclk_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            frame_ff <= '{state: ST_CMD, default: '0};
        end else begin
            frame_ff <= nxt_frame;
        end
    end

    // storage update and write report toggle
    always_comb begin
        nxt_store = store_ff;
        if (wr_done) begin
            // finished bytes survive a later abort
            nxt_store.wr_tgl = ~store_ff.wr_tgl;
            nxt_store.wr_addr = frame_ff.addr;
            nxt_store.wr_data = data_shift;
            // unmapped writes are dropped
            if (frame_ff.addr <= `LAST_REG) begin
                nxt_store.regs[frame_ff.addr[$clog2(`NUM_REGS)-1:0]] =
                    data_shift;
            end
        end
    end

    // storage only clears on system reset
    always_ff @(posedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            store_ff <= '0;
        end else begin
            store_ff <= nxt_store;
        end
    end

    // falling-edge launch logic

    // launch state and its next value
    launch_s launch_ff;
    launch_s nxt_launch;
    // byte fetched at the start of each read byte
    logic [`DATA_BITS-1:0] rd_byte;

    // pick the next read bit and the drive enables
    always_comb begin
        nxt_launch = launch_ff;
        rd_byte = read_byte(store_ff, frame_ff.addr);
        if (frame_ff.state == ST_RDATA) begin
            if (frame_ff.cnt == `CNT_ZERO) begin
                // first bit of a fresh byte
                if (cfg.high_bit_first) begin
                    nxt_launch.out_bit = rd_byte[`DATA_BITS-1];
                    nxt_launch.tx = {rd_byte[`DATA_BITS-2:0], 1'b0};
                end else begin
                    nxt_launch.out_bit = rd_byte[0];
                    nxt_launch.tx = {1'b0, rd_byte[`DATA_BITS-1:1]};
                end
            end else begin
                // remaining bits from the shift register
                if (cfg.high_bit_first) begin
                    nxt_launch.out_bit = launch_ff.tx[`DATA_BITS-1];
                    nxt_launch.tx = {launch_ff.tx[`DATA_BITS-2:0], 1'b0};
                end else begin
                    nxt_launch.out_bit = launch_ff.tx[0];
                    nxt_launch.tx = {1'b0, launch_ff.tx[`DATA_BITS-1:1]};
                end
            end
            // four-wire uses the output line only
            nxt_launch.oe_sep = cfg.separate_lines_mode;
            // three-wire turns the shared line round
            nxt_launch.oe_pin = ~cfg.separate_lines_mode;
        end else begin
            // not reading: float both lines
            nxt_launch.oe_sep = 1'b0;
            nxt_launch.oe_pin = 1'b0;
        end
    end

    // launch on the falling edge; select high floats all
    always_ff @(negedge sclk_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            launch_ff <= '0;
        end else begin
            launch_ff <= nxt_launch;
        end
    end

    // pins straight from the launch flops
    assign data_inout_pin_out = launch_ff.out_bit;
    assign data_inout_pin_oe_out = launch_ff.oe_pin;
    assign serial_data_out_out = launch_ff.out_bit;
    assign serial_data_out_oe_out = launch_ff.oe_sep;

    // system clock side: write reports and frame activity

    // synchronised {frame active, write toggle}
    logic [`HOST_SYNC_W-1:0] host_q;
    host_s host_ff;
    host_s nxt_host;

    // select level and write toggle cross by two flops
    level_sync #(
        .WIDTH(`HOST_SYNC_W),
        .RST_VAL('0)
    ) u_host_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .d_in({~chip_select_n_in, store_ff.wr_tgl}),
        .q_out(host_q)
    );

    // toggle edge captures the stable address and data
    always_comb begin
        nxt_host = host_ff;
        nxt_host.active = host_q[1];
        nxt_host.tgl_seen = host_q[0];
        nxt_host.wr_pulse = host_q[0] ^ host_ff.tgl_seen;
        if (host_q[0] ^ host_ff.tgl_seen) begin
            // held for a whole byte time, so safe to sample here
            nxt_host.wr_addr = store_ff.wr_addr;
            nxt_host.wr_data = store_ff.wr_data;
        end
    end

    // system side register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            host_ff <= '0;
        end else begin
            host_ff <= nxt_host;
        end
    end

    // report outputs straight from flops
    assign reg_wr_pulse_out = host_ff.wr_pulse;
    assign reg_wr_addr_out = host_ff.wr_addr;
    assign reg_wr_data_out = host_ff.wr_data;
    assign frame_active_out = host_ff.active;

endmodule : spi_port

`default_nettype wire

//--- spi_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_defines.svh"

// pin timing checks for the serial control port
module spi_port_properties
    import spi_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic separate_lines_mode_in,
    input wire logic sclk_in,
    input wire logic chip_select_n_in,
    input wire logic data_inout_pin_oe_out,
    input wire logic serial_data_out_oe_out,
    input wire logic reg_wr_pulse_out,
    input wire logic [`ADDR_BITS-1:0] reg_wr_addr_out,
    input wire logic [`DATA_BITS-1:0] reg_wr_data_out,
    input wire logic frame_active_out
);
    logic [5:0] edge_cnt_ff; // sclk rising edges so far in this frame
    wire logic oe_any = data_inout_pin_oe_out | serial_data_out_oe_out;

    // edge counter, cleared while deselected, saturates
    always_ff @(posedge sclk_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            edge_cnt_ff <= 6'h00;
        end else if (edge_cnt_ff != 6'h3F) begin
            edge_cnt_ff <= edge_cnt_ff + 6'h01;
        end
    end
    // control word complete
    sequence s_cmd_done;
        edge_cnt_ff == 6'h10;
    endsequence
    // first data byte complete
    sequence s_byte_done;
        edge_cnt_ff == 6'h18;
    endsequence
    property p_cmd_quiet;
        @(posedge sclk_in) disable iff (chip_select_n_in)
            edge_cnt_ff < 6'h10 |-> !oe_any;
    endproperty
    property p_oe_start;
        @(posedge sclk_in) disable iff (chip_select_n_in)
            $rose(oe_any) |-> s_cmd_done;
    endproperty
    property p_oe_end;
        @(posedge sclk_in) disable iff (chip_select_n_in)
            $fell(oe_any) && edge_cnt_ff != 6'h00 |-> s_byte_done;
    endproperty
    property p_wire_mode;
        @(posedge sclk_in) disable iff (chip_select_n_in)
            !(data_inout_pin_oe_out && separate_lines_mode_in) &&
            !(serial_data_out_oe_out && !separate_lines_mode_in);
    endproperty
    property p_float;
        @(posedge clk_in) disable iff (!arst_n_in)
            chip_select_n_in |-> !oe_any;
    endproperty
    property p_pulse_one;
        @(posedge clk_in) disable iff (!arst_n_in)
            reg_wr_pulse_out |=> !reg_wr_pulse_out;
    endproperty
    property p_report_hold;
        @(posedge clk_in) disable iff (!arst_n_in)
            !reg_wr_pulse_out |-> $stable({reg_wr_addr_out, reg_wr_data_out});
    endproperty
    property p_act_on;
        @(posedge clk_in) disable iff (!arst_n_in)
            $fell(chip_select_n_in) |-> ##[1:5] frame_active_out;
    endproperty
    property p_act_off;
        @(posedge clk_in) disable iff (!arst_n_in)
            $rose(chip_select_n_in) |-> ##[1:5] !frame_active_out;
    endproperty

    AST_CMD_QUIET: assert property (p_cmd_quiet)
        else $error("read enable during control word");
    AST_OE_START: assert property (p_oe_start)
        else $error("read enable rose at wrong edge");
    AST_OE_END: assert property (p_oe_end)
        else $error("read enable fell at wrong edge");
    AST_WIRE_MODE: assert property (p_wire_mode)
        else $error("wrong line enabled for wiring mode");
    AST_FLOAT: assert property (p_float)
        else $error("pin driven while deselected");
    AST_PULSE_ONE: assert property (p_pulse_one)
        else $error("write report longer than one cycle");
    AST_REPORT_HOLD: assert property (p_report_hold)
        else $error("write report changed without pulse");
    AST_ACT_ON: assert property (p_act_on)
        else $error("frame activity not seen");
    AST_ACT_OFF: assert property (p_act_off)
        else $error("frame activity not cleared");
endmodule : spi_port_properties

bind spi_port spi_port_properties u_spi_port_properties (.clk_in,
    .arst_n_in, .separate_lines_mode_in, .sclk_in, .chip_select_n_in,
    .data_inout_pin_oe_out, .serial_data_out_oe_out, .reg_wr_pulse_out,
    .reg_wr_addr_out, .reg_wr_data_out, .frame_active_out);
`default_nettype wire

//--- spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host side of the link; clock stands still between frames
module spi_host_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic d_out,
    output logic d_oe_out,
    input wire logic d_in
);
    // idle: deselected, clock low, line released
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        d_out = 1'b0;
        d_oe_out = 1'b0;
    end
    // one frame of n bits; n not on a byte edge aborts mid-byte
    task automatic frame(input logic [15:0] cmd, input logic [31:0] wd,
            input int n, input logic msb, output logic [31:0] rd);
        int k;
        int p;
        rd = '0;
        cs_n_out = 1'b0;
        #3;
        for (int i = 0; i < n; i++) begin
            k = i - 16;
            p = msb ? 7 - k % 8 : k % 8;
            if (i < 16) begin
                d_out = msb ? cmd[15 - i] : cmd[i];
                d_oe_out = 1'b1;
            end else begin
                d_out = wd[8 * (k / 8) + p];
                d_oe_out = ~cmd[15];
            end
            #3 sclk_out = 1'b1;
            if (i >= 16) begin
                rd[8 * (k / 8) + p] = d_in;
            end
            #3 sclk_out = 1'b0;
        end
        #3 cs_n_out = 1'b1;
        d_oe_out = 1'b0;
        #6;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- tb_spi_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "spi_port_defines.svh"

// self-checking bench for the serial control port
module tb_spi_port;
    logic clk_in = 1'b0; // system clock
    logic arst_n_in = 1'b0; // system reset
    logic high_bit_first = 1'b1; // settings at their defaults
    logic multi_byte_enable = 1'b0;
    logic address_step_up = 1'b1;
    logic separate_lines_mode = 1'b1;
    logic sclk, cs_n, host_d, host_oe; // host pins
    logic dio_out, dio_oe, sdo_out, sdo_oe, wr_pulse, active;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic [31:0] rd_v; // read bytes, first byte lowest
    logic [22:0] rep_q[$]; // write reports collected
    int error_cnt = 0;
    int comparisons = 0;
    // shared line: device, host, else a changing float pattern
    wire logic din = dio_oe ? dio_out : (host_oe ? host_d : ~sclk);
    // line the host reads back on
    wire logic rx = separate_lines_mode ? (sdo_oe ? sdo_out : ~sclk) : din;

    always #5 clk_in = ~clk_in;

    spi_port u_spi_port (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .high_bit_first_in(high_bit_first),
        .multi_byte_enable_in(multi_byte_enable),
        .address_step_up_in(address_step_up),
        .separate_lines_mode_in(separate_lines_mode),
        .sclk_in(sclk), .chip_select_n_in(cs_n), .data_inout_pin_in(din),
        .data_inout_pin_out(dio_out), .data_inout_pin_oe_out(dio_oe),
        .serial_data_out_out(sdo_out), .serial_data_out_oe_out(sdo_oe),
        .reg_wr_pulse_out(wr_pulse), .reg_wr_addr_out(wr_addr),
        .reg_wr_data_out(wr_data), .frame_active_out(active));
    spi_host_model u_spi_host_model (.sclk_out(sclk), .cs_n_out(cs_n),
        .d_out(host_d), .d_oe_out(host_oe), .d_in(rx));

    // collect write reports away from the clock edge
    always @(negedge clk_in) begin
        if (wr_pulse === 1'b1) begin
            rep_q.push_back({wr_addr, wr_data});
        end
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one frame, then time for the report to cross
    task automatic xfer(input logic [15:0] cmd, input logic [31:0] wd,
            input int n);
        u_spi_host_model.frame(cmd, wd, n, high_bit_first, rd_v);
        repeat (6) @(posedge clk_in);
        // next select edge lands away from the system clock edge
        @(negedge clk_in);
    endtask : xfer
    // next expected write report
    task automatic rep(input logic [14:0] a, input logic [7:0] d);
        logic [22:0] r;
        r = 23'h7FFFFF;
        if (rep_q.size() > 0) begin
            r = rep_q.pop_front();
        end
        chk({9'h000, r}, {9'h000, a, d});
    endtask : rep
    // new settings, then an aborted frame to settle them
    task automatic cfg(input logic m, input logic b, input logic u,
            input logic s);
        @(negedge clk_in);
        high_bit_first = m;
        multi_byte_enable = b;
        address_step_up = u;
        separate_lines_mode = s;
        xfer(16'h0000, 32'h0, 4);
        chk(rep_q.size(), 0);
    endtask : cfg
    // high bit first single bytes; bits past the byte ignored
    task automatic t_single;
        cfg(1'b1, 1'b0, 1'b1, 1'b1);
        xfer(16'h000A, 32'h55, 24);
        rep(15'h00A, 8'h55);
        xfer(16'h800A, 32'h0, 32);
        chk(rd_v[7:0], 8'h55);
        xfer(16'h000B, 32'h9922, 32);
        rep(15'h00B, 8'h22);
        chk(rep_q.size(), 0);
        $display("done single");
    endtask : t_single
    // low bit first, streaming up across the last register
    task automatic t_up;
        cfg(1'b0, 1'b1, 1'b1, 1'b1);
        xfer(16'h000F, 32'h6C3A, 32);
        rep(15'h00F, 8'h3A);
        rep(15'h000, 8'h6C);
        xfer(16'h800F, 32'h0, 32);
        chk(rd_v[15:0], 16'h6C3A);
        $display("done up");
    endtask : t_up
    // streaming down, partial byte at abort, early aborts
    task automatic t_down;
        cfg(1'b1, 1'b1, 1'b0, 1'b1);
        xfer(16'h0001, 32'hC3B2A1, 35);
        rep(15'h001, 8'hA1);
        rep(15'h000, 8'hB2);
        xfer(16'h000A, 32'hFF, 10);
        xfer(16'h000A, 32'hFF, 20);
        chk(rep_q.size(), 0);
        xfer(16'h8001, 32'h0, 40);
        chk(rd_v[23:0], 24'h3AB2A1);
        xfer(16'h800A, 32'h0, 24);
        chk(rd_v[7:0], 8'h55);
        $display("done down");
    endtask : t_down
    // shared line reads and an undefined address
    task automatic t_three;
        cfg(1'b1, 1'b0, 1'b1, 1'b0);
        xfer(16'h800A, 32'h0, 24);
        chk(rd_v[7:0], 8'h55);
        xfer(16'h0100, 32'h77, 24);
        rep(15'h100, 8'h77);
        xfer(16'h8100, 32'h0, 24);
        chk(rd_v[7:0], 8'h00);
        $display("done three");
    endtask : t_three
    // counts, verdict, stop
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // reset, then scenarios in order
    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        arst_n_in = 1'b1;
        t_single();
        t_up();
        t_down();
        t_three();
        end_of_test();
    end
    // watchdog well past the expected run
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule : tb_spi_port
`default_nettype wire
